/* File: core/rtcor_regs.v */
// AHB-Lite register block: capture image, alarm, load capacitance and pin control
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rtcor_defines.vh"
module rtcor_regs #(
   parameter STEP_CYCLES = (`RTCOR_STEP_TIME_NS + `RTCOR_CLK_PERIOD_NS - 1) / `RTCOR_CLK_PERIOD_NS
) (
   input wire clock_in,
   input wire arst_n_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output reg [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   output wire xtal_pin_short_out,
   output wire [3:0] applied_cap_out,
   output wire alarm_event_out,
   output wire [31:0] timer_out
);
   // Address phase capture
   reg wr_pend_ff;
   reg [3:0] wr_idx_ff;
   reg [31:0] snap_ff;
   reg [31:0] alarm_ff;
   reg step_en_ff;
   reg [3:0] target_ff;
   reg pin_short_ff;
   reg [6:0] pin_rsvd_ff;
   reg snap_req_ff;
   reg load_req_ff;
   reg alarm_en_ff;
   reg timer_en_ff;
   reg alarm_seen_ff;
   reg [31:0] nxt_rdata;
   wire addr_ok;
   wire take;
   wire [3:0] idx;
   wire settled;
   wire alarm_hit;
   wire [31:0] count;
   wire [7:0] wb;

   assign idx = haddr_in[5:2];
   assign addr_ok = (haddr_in[31:6] == 26'h0) && (haddr_in[1:0] == 2'b00);
   assign take = hsel_in && hready_in && htrans_in[1];
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign wb = hwdata_in[7:0];
   assign xtal_pin_short_out = pin_short_ff;
   assign alarm_event_out = alarm_hit;
   assign timer_out = count;

   // Read data registered in the address phase, so it stands in the data phase
   always @* begin
      nxt_rdata = 32'h00000000;
      case (idx)
         `RTCOR_IDX_SNAP0: nxt_rdata = {24'h0, snap_ff[7:0]};
         `RTCOR_IDX_SNAP1: nxt_rdata = {24'h0, snap_ff[15:8]};
         `RTCOR_IDX_SNAP2: nxt_rdata = {24'h0, snap_ff[23:16]};
         `RTCOR_IDX_SNAP3: nxt_rdata = {24'h0, snap_ff[31:24]};
         `RTCOR_IDX_CTRL: nxt_rdata = {27'h0, alarm_seen_ff, timer_en_ff, alarm_en_ff,
            load_req_ff, snap_req_ff};
         `RTCOR_IDX_LOAD_CAP_TARGET: nxt_rdata = {24'h0, step_en_ff, settled, 2'b00, target_ff};
         `RTCOR_IDX_PINCFG: nxt_rdata = {24'h0, 1'b0, pin_rsvd_ff}; // Short bit is write-only
         `RTCOR_IDX_ALARM_MATCH_BYTE0: nxt_rdata = {24'h0, alarm_ff[7:0]};
         `RTCOR_IDX_ALARM_MATCH_BYTE1: nxt_rdata = {24'h0, alarm_ff[15:8]};
         `RTCOR_IDX_ALARM_MATCH_BYTE2: nxt_rdata = {24'h0, alarm_ff[23:16]};
         `RTCOR_IDX_ALARM_MATCH_BYTE3: nxt_rdata = {24'h0, alarm_ff[31:24]};
         default: nxt_rdata = 32'h00000000;
      endcase
      if (!addr_ok) begin
         nxt_rdata = 32'h00000000; // Unmapped reads as zero
      end
   end

   // Bus bookkeeping
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff <= 4'h0;
         hrdata_out <= 32'h00000000;
      end else begin
         wr_pend_ff <= take && hwrite_in && addr_ok;
         wr_idx_ff <= idx;
         if (take && !hwrite_in) begin
            hrdata_out <= nxt_rdata;
         end
      end
   end

   // Register writes; request bits self-clear on the same edge that they act
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         snap_ff <= 32'h00000000;
         alarm_ff <= 32'h00000000;
         step_en_ff <= 1'b0;
         target_ff <= `RTCOR_LC_TARGET_RST;
         pin_short_ff <= 1'b0;
         pin_rsvd_ff <= `RTCOR_PIN_RSVD_RST;
         snap_req_ff <= 1'b0;
         load_req_ff <= 1'b0;
         alarm_en_ff <= 1'b0;
         timer_en_ff <= 1'b0;
         alarm_seen_ff <= 1'b0;
      end else begin
         snap_req_ff <= 1'b0;
         load_req_ff <= 1'b0;
         if (snap_req_ff) begin
            snap_ff <= count;
         end
         if (wr_pend_ff) begin
            case (wr_idx_ff)
               `RTCOR_IDX_SNAP0: snap_ff[7:0] <= wb;
               `RTCOR_IDX_SNAP1: snap_ff[15:8] <= wb;
               `RTCOR_IDX_SNAP2: snap_ff[23:16] <= wb;
               `RTCOR_IDX_SNAP3: snap_ff[31:24] <= wb;
               `RTCOR_IDX_CTRL: begin
                  snap_req_ff <= wb[`RTCOR_CTRL_SNAP_BIT];
                  load_req_ff <= wb[`RTCOR_CTRL_LOAD_BIT];
                  alarm_en_ff <= wb[`RTCOR_CTRL_AEN_BIT];
                  timer_en_ff <= wb[`RTCOR_CTRL_TEN_BIT];
               end
               `RTCOR_IDX_LOAD_CAP_TARGET: begin
                  step_en_ff <= wb[`RTCOR_LC_STEP_BIT];
                  target_ff <= wb[`RTCOR_LC_TARGET_MSB:0];
               end
               `RTCOR_IDX_PINCFG: begin
                  pin_short_ff <= wb[`RTCOR_PIN_SHORT_BIT];
                  pin_rsvd_ff <= wb[6:0];
               end
               `RTCOR_IDX_ALARM_MATCH_BYTE0: alarm_ff[7:0] <= wb;
               `RTCOR_IDX_ALARM_MATCH_BYTE1: alarm_ff[15:8] <= wb;
               `RTCOR_IDX_ALARM_MATCH_BYTE2: alarm_ff[23:16] <= wb;
               `RTCOR_IDX_ALARM_MATCH_BYTE3: alarm_ff[31:24] <= wb;
               default: ;
            endcase
         end
         // Sticky alarm seen; set wins over a write-one clear
         if (alarm_hit) begin
            alarm_seen_ff <= 1'b1;
         end else if (wr_pend_ff && wr_idx_ff == `RTCOR_IDX_CTRL && wb[`RTCOR_CTRL_ALARM_BIT]) begin
            alarm_seen_ff <= 1'b0;
         end
      end
   end

   // Capacitance stepper
   rtcor_cap_stepper #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_stepper (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .step_en_in(step_en_ff),
      .target_in(target_ff),
      .applied_out(applied_cap_out),
      .settled_out(settled)
   );

   // Timer, preset from the capture image on a load request
   rtcor_timer u_timer (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .run_in(timer_en_ff),
      .load_in(load_req_ff),
      .load_val_in(snap_ff),
      .alarm_val_in(alarm_ff),
      .alarm_en_in(alarm_en_ff),
      .count_out(count),
      .alarm_hit_out(alarm_hit)
   );
endmodule // rtcor_regs
`default_nettype wire

/* File: pkg/rtcor_defines.vh */
// Register map, field positions, reset values and timing counts of the RTC register block
// Behaviour
// - When the auto step enable bit 7 is set, the applied load capacitance walks toward the target instead of jumping.
// - Read-only bit 6 reads 1 when the applied code equals the target and 0 while stepping.
// - Bits 5 and 4 of the load capacitance register read zero and ignore writes.
// - Bits 3 to 0 of the load capacitance register hold the target code, with a device-specific reset value.
// - Writing 1 to pin configuration bit 7 shorts the two oscillator pins; 0 leaves them normal.
// - Four capture bytes form a 32-bit timer image used to read and preset the timer.
// - A load request copies the image into the timer and a snapshot request copies the timer into the image.
// - Four alarm bytes, reset to zero, hold a 32-bit value compared against the timer to raise an alarm event.
// - Alarm bits 7 to 0 sit in the alarm byte at index 0x08, the rest at the three indices above.
// - The snapshot and load request bits self-clear once their transfer is complete.
`ifndef RTCOR_DEFINES_VH
`define RTCOR_DEFINES_VH
// Register indices; byte address is four times the index
`define RTCOR_IDX_SNAP0 4'h0
`define RTCOR_IDX_SNAP1 4'h1
`define RTCOR_IDX_SNAP2 4'h2
`define RTCOR_IDX_SNAP3 4'h3
`define RTCOR_IDX_CTRL 4'h4
`define RTCOR_IDX_LOAD_CAP_TARGET 4'h6
`define RTCOR_IDX_PINCFG 4'h7
`define RTCOR_IDX_ALARM_MATCH_BYTE0 4'h8
`define RTCOR_IDX_ALARM_MATCH_BYTE1 4'h9
`define RTCOR_IDX_ALARM_MATCH_BYTE2 4'ha
`define RTCOR_IDX_ALARM_MATCH_BYTE3 4'hb
// Control register fields
`define RTCOR_CTRL_SNAP_BIT 0
`define RTCOR_CTRL_LOAD_BIT 1
`define RTCOR_CTRL_AEN_BIT 2
`define RTCOR_CTRL_TEN_BIT 3
`define RTCOR_CTRL_ALARM_BIT 4
// Load capacitance register fields
`define RTCOR_LC_STEP_BIT 7
`define RTCOR_LC_SETTLED_BIT 6
`define RTCOR_LC_TARGET_MSB 3
`define RTCOR_LC_TARGET_RST 4'h0
// Pin configuration register fields
`define RTCOR_PIN_SHORT_BIT 7
`define RTCOR_PIN_RSVD_RST 7'h00
// Stepping interval
`define RTCOR_STEP_TIME_NS 1000
`define RTCOR_CLK_PERIOD_NS 10
`endif

/* File: core/rtcor_cap_stepper.v */
// Load capacitance stepper: walks the applied code toward the target
`timescale 1ns/1ps
`default_nettype none
`include "rtcor_defines.vh"
module rtcor_cap_stepper #(
   parameter STEP_CYCLES = 100
) (
   input wire clock_in,
   input wire arst_n_in,
   input wire step_en_in,
   input wire [3:0] target_in,
   output wire [3:0] applied_out,
   output wire settled_out
);
   reg [3:0] applied_ff;
   reg [15:0] tick_ff;
   wire tick_done;

   assign tick_done = (tick_ff == STEP_CYCLES[15:0] - 16'h0001);
   assign applied_out = applied_ff;
   assign settled_out = (applied_ff == target_in);

   // Interval counter only runs while stepping is pending
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_ff <= 16'h0000;
      end else if (!step_en_in || settled_out || tick_done) begin
         tick_ff <= 16'h0000;
      end else begin
         tick_ff <= tick_ff + 16'h0001;
      end
   end

   // One step per interval, or a direct jump when stepping is off
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         applied_ff <= `RTCOR_LC_TARGET_RST;
      end else if (!step_en_in) begin
         applied_ff <= target_in;
      end else if (tick_done && !settled_out) begin
         if (applied_ff < target_in) begin
            applied_ff <= applied_ff + 4'h1;
         end else begin
            applied_ff <= applied_ff - 4'h1;
         end
      end
   end
endmodule // rtcor_cap_stepper
`default_nettype wire

/* File: core/rtcor_timer.v */
// 32-bit timer with load port and alarm compare
`timescale 1ns/1ps
`default_nettype none
module rtcor_timer (
   input wire clock_in,
   input wire arst_n_in,
   input wire run_in,
   input wire load_in,
   input wire [31:0] load_val_in,
   input wire [31:0] alarm_val_in,
   input wire alarm_en_in,
   output wire [31:0] count_out,
   output reg alarm_hit_out
);
   reg [31:0] count_ff;
   assign count_out = count_ff;

   // Load wins over counting so a preset is exact
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_ff <= 32'h00000000;
      end else if (load_in) begin
         count_ff <= load_val_in;
      end else if (run_in) begin
         count_ff <= count_ff + 32'h00000001;
      end
   end

   // Registered alarm event on match; one cycle long while the timer runs, held while it stops on a match
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alarm_hit_out <= 1'b0;
      end else begin
         alarm_hit_out <= alarm_en_in && (count_ff == alarm_val_in);
      end
   end
endmodule // rtcor_timer
`default_nettype wire

/* File: test/rtcor_regs_sva.sv */
// Port assertions for the RTC register block
`timescale 1ns/1ps
`default_nettype none
module rtcor_regs_sva (
   input wire clock_in,
   input wire arst_n_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire [31:0] hrdata_out,
   input wire hreadyout_out,
   input wire hresp_out,
   input wire xtal_pin_short_out,
   input wire [3:0] applied_cap_out
);
   reg ph_ff, wr_ff, jmp_ff, jd_ff;
   reg [7:0] a_ff;
   reg [3:0] tgt_ff;
   wire lc_wr = ph_ff & wr_ff & (a_ff == 8'h18);
   wire rd_ph = ph_ff & ~wr_ff;
   // Track data phases and a shadow of the target code
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ph_ff <= 1'b0;
         wr_ff <= 1'b0;
         jmp_ff <= 1'b0;
         jd_ff <= 1'b0;
         a_ff <= 8'h00;
         tgt_ff <= 4'h0;
      end else begin
         ph_ff <= hsel_in & hready_in & htrans_in[1];
         wr_ff <= hwrite_in;
         a_ff <= haddr_in[7:0];
         jmp_ff <= lc_wr & ~hwdata_in[7];
         jd_ff <= jmp_ff; // Jump may land one edge late
         if (lc_wr) tgt_ff <= hwdata_in[3:0];
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence pin_wr_s;
      ph_ff && wr_ff && a_ff == 8'h1c;
   endsequence
   sequence lc_read_s;
      rd_ph && a_ff == 8'h18;
   endsequence
   bus_okay_a: assert property (hreadyout_out && !hresp_out)
      else $error("bus not ready or not okay");
   pin_short_a: assert property (pin_wr_s |=> xtal_pin_short_out == $past(hwdata_in[7]))
      else $error("pin short does not follow write");
   pin_read_a: assert property (rd_ph && a_ff == 8'h1c |-> !hrdata_out[7])
      else $error("pin short bit reads back");
   cap_jump_a: assert property (lc_wr && !hwdata_in[7] |-> ##2 applied_cap_out == tgt_ff)
      else $error("direct cap not applied");
   cap_step_a: assert property (!jmp_ff && !jd_ff && $changed(applied_cap_out)
      |-> 4'(applied_cap_out - $past(applied_cap_out)) inside {4'h1, 4'hf})
      else $error("cap moved more than one step");
   cap_still_a: assert property (applied_cap_out == tgt_ff && !lc_wr |=> $stable(applied_cap_out))
      else $error("settled cap moved");
   lc_read_a: assert property (lc_read_s |-> hrdata_out[6:0]
      == {$past(applied_cap_out) == $past(tgt_ff), 2'h0, $past(tgt_ff)})
      else $error("cap config reads wrong");
   unmapped_a: assert property (rd_ph && a_ff == 8'h14 |-> hrdata_out == 32'h0)
      else $error("unmapped read not zero");
endmodule // rtcor_regs_sva
bind rtcor_regs rtcor_regs_sva i_rtcor_regs_sva (.clock_in(clock_in), .arst_n_in(arst_n_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .xtal_pin_short_out(xtal_pin_short_out), .applied_cap_out(applied_cap_out));
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the RTC register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock_in, arst_n_in, hsel, hwrite;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, v;
   wire [31:0] hrdata, timer;
   wire [3:0] cap;
   wire hready, short_pin, alarm;
   int bad_count = 0, check_count = 0, cyc = 0, i;
   rtcor_regs #(.STEP_CYCLES(2)) i_rtcor_regs (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(), .xtal_pin_short_out(short_pin),
      .applied_cap_out(cap), .alarm_event_out(alarm), .timer_out(timer));
   initial begin
      clock_in = 0;
      forever #5 clock_in = ~clock_in;
   end
   task summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // One single AHB transfer; the data phase result lands in v
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      v = hrdata;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      chk(n, e, v);
   endtask
   task settle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   // Hang guard well above the few hundred cycles the run needs
   always @(posedge clock_in) begin
      cyc++;
      if (cyc > 4000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      arst_n_in = 0;
      hsel = 1;
      htrans = 0;
      haddr = 0;
      hwrite = 0;
      hwdata = 0;
      repeat (4) @(posedge clock_in);
      arst_n_in <= 1;
      for (i = 0; i < 12; i++) if (i < 4 || i > 7) rdc(8'(4 * i), 0, "reset byte");
      rdc(8'h18, 32'h40, "cap reset");
      xfer(1'b1, 8'h14, 32'hff);
      rdc(8'h14, 0, "unmapped");
      // Pin short set and cleared by read-modify-write
      xfer(1'b1, 8'h1c, 32'h05);
      rdc(8'h1c, 32'h05, "pin cfg");
      xfer(1'b1, 8'h1c, v | 32'h80);
      settle(1);
      chk("short on", 1, short_pin);
      rdc(8'h1c, 32'h05, "pin keep");
      xfer(1'b1, 8'h1c, v & 32'h7f);
      settle(1);
      chk("short off", 0, short_pin);
      // Direct then stepped load capacitance
      xfer(1'b1, 8'h18, 32'h3a);
      settle(2);
      chk("cap jump", 32'ha, cap);
      rdc(8'h18, 32'h4a, "cap cfg");
      xfer(1'b1, 8'h18, 32'h83);
      rdc(8'h18, 32'h83, "stepping");
      // Look just after each edge so the output has settled
      for (i = 0; i < 200 && cap !== 4'h3; i++) begin
         @(posedge clock_in);
         #1;
      end
      chk("step span", 1, i >= 6);
      rdc(8'h18, 32'hc3, "stepped");
      // Preset the timer from the image, then capture it back
      for (i = 0; i < 4; i++) xfer(1'b1, 8'(4 * i), 32'h11 * (i + 1));
      xfer(1'b1, 8'h10, 32'h2);
      settle(3);
      chk("timer load", 32'h44332211, timer);
      rdc(8'h10, 0, "request clear");
      for (i = 0; i < 4; i++) xfer(1'b1, 8'(4 * i), 32'h0);
      xfer(1'b1, 8'h10, 32'h1);
      settle(3);
      for (i = 0; i < 4; i++) rdc(8'(4 * i), 32'h11 * (i + 1), "snapshot");
      // Alarm written while disabled, then armed with the timer running
      for (i = 0; i < 4; i++) xfer(1'b1, 8'(32 + 4 * i), 32'h44332239 >> (8 * i) & 32'hff);
      rdc(8'h20, 32'h39, "alarm low");
      rdc(8'h2c, 32'h44, "alarm high");
      xfer(1'b1, 8'h10, 32'hc);
      // The alarm pulse stands one cycle, so sample it off the edge
      for (i = 0; i < 200 && alarm !== 1'b1; i++) begin
         @(posedge clock_in);
         #1;
      end
      chk("alarm seen", 1, i < 200);
      chk("alarm time", 1, timer - 32'h44332239 <= 2);
      // Sticky seen bit reads back, then a write of one clears it
      rdc(8'h10, 32'h1c, "alarm sticky");
      xfer(1'b1, 8'h10, 32'h10);
      rdc(8'h10, 0, "alarm clear");
      summarize();
   end
endmodule // tb
`default_nettype wire
